// ### rtl/bsx_pkg.sv
/*
 * Shared constants for the branch and system instruction execute unit:
 * encodings, special register selectors, APB register map and reset values.
 * Assumes 16-bit instruction halfwords with the first halfword in the low bits.
 */
package bsx_pkg;
    // APB register byte offsets
    localparam logic [7:0] BSX_ADDR_CTRL = 8'h00;
    localparam logic [7:0] BSX_ADDR_STATUS = 8'h04;
    // Control register fields
    localparam int BSX_CTRL_SLEEP_NOP = 0;
    localparam int BSX_CTRL_DEBUG_HALT_INSTR_LOCKUP = 1;
    localparam int BSX_CTRL_WAKE_PEND = 2;
    localparam logic [2:0] BSX_CTRL_RESET = 3'h0;
    // Status register fields
    localparam int BSX_STAT_EVENT = 0;
    localparam int BSX_STAT_INTERRUPT_MASK_BIT = 1;
    localparam int BSX_STAT_TBIT = 2;
    localparam int BSX_STAT_SLEEP = 3;
    localparam int BSX_STAT_LOCKUP = 4;
    localparam int BSX_STAT_FLAGS = 28;
    // Single-halfword encodings
    localparam logic [15:0] BSX_ENC_MASK_CLR = 16'hb662;
    localparam logic [15:0] BSX_ENC_MASK_SET = 16'hb672;
    localparam logic [15:0] BSX_ENC_NOP = 16'hbf00;
    localparam logic [15:0] BSX_ENC_WFE = 16'hbf20;
    localparam logic [15:0] BSX_ENC_WFI = 16'hbf30;
    localparam logic [15:0] BSX_ENC_SEV = 16'hbf40;
    localparam logic [7:0] BSX_ENC_DEBUG_HALT_INSTR = 8'hbe;
    localparam logic [7:0] BSX_ENC_SVC = 8'hdf;
    localparam logic [7:0] BSX_ENC_BXL = 8'h47;
    // Two-halfword encodings
    localparam logic [15:0] BSX_ENC_BAR_HW1 = 16'hf3bf;
    localparam logic [7:0] BSX_ENC_BAR_HW2 = 8'h8f;
    localparam logic [3:0] BSX_BAR_DSB = 4'h4;
    localparam logic [3:0] BSX_BAR_DMB = 4'h5;
    localparam logic [3:0] BSX_BAR_ISB = 4'h6;
    localparam logic [15:0] BSX_ENC_MRS_HW1 = 16'hf3ef;
    localparam logic [11:0] BSX_ENC_MSR_HW1 = 12'hf38;
    localparam logic [7:0] BSX_ENC_MSR_HW2 = 8'h88;
    // Special register selectors
    localparam logic [7:0] BSX_SYS_MSP = 8'h08;
    localparam logic [7:0] BSX_SYS_PSP = 8'h09;
    localparam logic [7:0] BSX_SYS_INTERRUPT_MASK_BIT = 8'h10;
    localparam logic [7:0] BSX_SYS_CONTROL = 8'h14;
    // Return address register index and return offsets
    localparam logic [3:0] BSX_LR_IDX = 4'he;
    localparam logic [31:0] BSX_PC_AHEAD = 32'h4;
    localparam logic [31:0] BSX_NEXT_HALF = 32'h2;
endpackage : bsx_pkg

// ### rtl/bsx_exec.sv
/*
 * Branch and system instruction execute unit: branches, link branches,
 * mask set/clear, barriers, special register moves, hints and sleep.
 * Assumes a fetch stage presenting one decoded-width instruction with its PC,
 * a register file answering REG_IDX_O combinationally on REG_DATA_I,
 * and an APB master for the control and status registers.
 */
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module bsx_exec
    import bsx_pkg::*;
#(
    parameter int APB_AW = 8
) (
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    // Instruction stream
    input wire logic INSTR_VALID_I,
    input wire logic [31:0] INSTR_I,
    input wire logic [31:0] PC_I,
    output logic INSTR_READY_O,
    // Register file port
    output logic [3:0] REG_IDX_O,
    input wire logic [31:0] REG_DATA_I,
    // Flag updates from the arithmetic unit, and the exception number for special register reads
    input wire logic FLAGS_WE_I,
    input wire logic [3:0] FLAGS_I,
    input wire logic [5:0] EXC_NUM_I,
    // System inputs
    input wire logic MEM_IDLE_I,
    input wire logic DEBUGGER_I,
    input wire logic DBG_EN_I,
    input wire logic DBG_REQ_I,
    input wire logic EXC_REQ_I,
    input wire logic PEND_NEW_I,
    input wire logic PEND_PREEMPT_I,
    input wire logic EXT_EVENT_I,
    // Results
    output logic BRANCH_O,
    output logic [31:0] TARGET_O,
    output logic RD_WE_O,
    output logic [3:0] RD_IDX_O,
    output logic [31:0] RD_DATA_O,
    output logic FATAL_FAULT_O,
    output logic SVC_O,
    output logic DEBUG_HALT_O,
    output logic LOCKUP_O,
    output logic FLUSH_O,
    output logic EVENT_OUT_O,
    output logic SLEEP_O,
    output logic [3:0] FLAGS_O,
    output logic INTERRUPT_MASK_BIT_O,
    output logic TBIT_O,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [APB_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    // The register map needs at least a byte-addressed word pair
    if (APB_AW < 3 || APB_AW > 8) begin : g_aw_check
        $error("APB_AW must lie between 3 and 8");
    end

    typedef enum logic [2:0] {BSX_IDLE, BSX_MEMWAIT, BSX_SLEEP_EVT, BSX_SLEEP_INT,
                              BSX_LOCK} bsx_state_t;

    typedef struct packed {
        bsx_state_t st;
        logic evt;
        logic interrupt_mask_bit;
        logic tbit;
        logic [3:0] flags;
        logic spsel;
        logic [31:0] msp;
        logic [31:0] psp;
        logic [2:0] ctrl;
        logic isb_pend;
        logic branch;
        logic [31:0] target;
        logic rd_we;
        logic [3:0] rd_idx;
        logic [31:0] rd_data;
        logic fault;
        logic supervisor_call;
        logic halt;
        logic flush;
        logic send_event;
        logic [31:0] prdata;
        logic pslverr;
    } bsx_regs_t;

    bsx_regs_t r;
    bsx_regs_t next_r;

    logic [15:0] hw1;
    logic [15:0] hw2;
    logic accept;
    logic is_bcond, is_b, is_bl, is_bxl, is_debug_halt_instr, is_svc, is_mrs, is_msr, is_bar;
    logic [31:0] off_cond, off_b, off_bl, pc_ahead;
    logic bl_s;
    logic [7:0] sysm;
    logic [31:0] spec_val;
    logic [7:0] apb_off;
    logic apb_hit;

    // Condition check on N Z C V; only the conditional branch calls it
    function automatic logic bsx_cond(input logic [3:0] c, input logic [3:0] f);
        logic res;
        res = 1'b0;
        unique case (c[3:1])
            3'h0: res = f[2];
            3'h1: res = f[1];
            3'h2: res = f[3];
            3'h3: res = f[0];
            3'h4: res = f[1] & ~f[2];
            3'h5: res = f[3] == f[0];
            3'h6: res = ~f[2] & (f[3] == f[0]);
            3'h7: res = 1'b1;
        endcase
        return res ^ c[0];
    endfunction : bsx_cond

    // Decode of the instruction word
    assign hw1 = INSTR_I[15:0];
    assign hw2 = INSTR_I[31:16];
    assign INSTR_READY_O = (r.st == BSX_IDLE);
    assign accept = INSTR_VALID_I & INSTR_READY_O;
    assign is_bcond = (hw1[15:12] == 4'hd) && (hw1[11:9] != 3'h7);
    assign is_b = (hw1[15:11] == 5'h1c);
    assign is_bl = (hw1[15:11] == 5'h1e) && (hw2[15:14] == 2'h3) && hw2[12];
    assign is_bxl = (hw1[15:8] == BSX_ENC_BXL) && (hw1[2:0] == 3'h0);
    assign is_debug_halt_instr = (hw1[15:8] == BSX_ENC_DEBUG_HALT_INSTR);
    assign is_svc = (hw1[15:8] == BSX_ENC_SVC);
    assign is_mrs = (hw1 == BSX_ENC_MRS_HW1) && (hw2[15:12] == 4'h8);
    assign is_msr = (hw1[15:4] == BSX_ENC_MSR_HW1) && (hw2[15:8] == BSX_ENC_MSR_HW2);
    assign is_bar = (hw1 == BSX_ENC_BAR_HW1) && (hw2[15:8] == BSX_ENC_BAR_HW2);
    assign sysm = hw2[7:0];
    assign REG_IDX_O = is_msr ? hw1[3:0] : hw1[6:3];

    assign off_cond = {{23{hw1[7]}}, hw1[7:0], 1'b0};
    assign off_b = {{20{hw1[10]}}, hw1[10:0], 1'b0};
    assign bl_s = hw1[10];
    assign off_bl = {{7{bl_s}}, bl_s, ~(hw2[13] ^ bl_s), ~(hw2[11] ^ bl_s), hw1[9:0],
                     hw2[10:0], 1'b0};
    assign pc_ahead = PC_I + BSX_PC_AHEAD;

    // special register read value; the state view reads as zero
    always_comb begin
        spec_val = 32'h0;
        if (sysm[7:3] == 5'h0) begin
            spec_val[31:28] = sysm[2] ? 4'h0 : r.flags;
            spec_val[5:0] = sysm[0] ? EXC_NUM_I : 6'h0;
        end else if (sysm == BSX_SYS_MSP) begin
            spec_val = r.msp;
        end else if (sysm == BSX_SYS_PSP) begin
            spec_val = r.psp;
        end else if (sysm == BSX_SYS_INTERRUPT_MASK_BIT) begin
            spec_val = {31'h0, r.interrupt_mask_bit};
        end else if (sysm == BSX_SYS_CONTROL) begin
            spec_val = {30'h0, r.spsel, 1'b0};
        end
    end

    assign apb_off = 8'(PADDR);
    assign apb_hit = (apb_off == BSX_ADDR_CTRL) || (apb_off == BSX_ADDR_STATUS);

    // Next-state logic for the whole unit
    always_comb begin
        next_r = r;
        next_r.branch = 1'b0;
        next_r.rd_we = 1'b0;
        next_r.fault = 1'b0;
        next_r.supervisor_call = 1'b0;
        next_r.halt = 1'b0;
        next_r.flush = 1'b0;
        next_r.send_event = 1'b0;
        // Arithmetic flag writes; branch paths below never touch flags
        if (FLAGS_WE_I) begin
            next_r.flags = FLAGS_I;
        end
        unique case (r.st)
            BSX_IDLE: begin
                if (accept) begin
                    if (is_bcond) begin
                        if (bsx_cond(hw1[11:8], r.flags)) begin
                            next_r.branch = 1'b1;
                            next_r.target = pc_ahead + off_cond;
                        end
                    end else if (is_b) begin
                        next_r.branch = 1'b1;
                        next_r.target = pc_ahead + off_b;
                    end else if (is_bl) begin
                        next_r.branch = 1'b1;
                        next_r.target = pc_ahead + off_bl;
                        next_r.rd_we = 1'b1;
                        next_r.rd_idx = BSX_LR_IDX;
                        next_r.rd_data = pc_ahead | 32'h1;
                    end else if (is_bxl) begin
                        next_r.tbit = REG_DATA_I[0];
                        next_r.target = {REG_DATA_I[31:1], 1'b0};
                        if (!REG_DATA_I[0]) begin
                            next_r.fault = 1'b1;
                        end else begin
                            next_r.branch = 1'b1;
                            next_r.rd_we = hw1[7];
                            next_r.rd_idx = BSX_LR_IDX;
                            next_r.rd_data = (PC_I + BSX_NEXT_HALF) | 32'h1;
                        end
                    end else if (is_debug_halt_instr) begin
                        if (DEBUGGER_I) begin
                            next_r.halt = 1'b1;
                        end else if (r.ctrl[BSX_CTRL_DEBUG_HALT_INSTR_LOCKUP]) begin
                            next_r.st = BSX_LOCK;
                        end else begin
                            next_r.fault = 1'b1;
                        end
                    end else if (is_svc) begin
                        next_r.supervisor_call = 1'b1;
                    end else if (hw1 == BSX_ENC_MASK_SET) begin
                        next_r.interrupt_mask_bit = 1'b1;
                    end else if (hw1 == BSX_ENC_MASK_CLR) begin
                        next_r.interrupt_mask_bit = 1'b0;
                    end else if (is_bar) begin
                        if (hw2[7:4] == BSX_BAR_DSB || hw2[7:4] == BSX_BAR_DMB) begin
                            next_r.st = BSX_MEMWAIT;
                        end else if (hw2[7:4] == BSX_BAR_ISB) begin
                            next_r.flush = 1'b1;
                        end
                    end else if (is_mrs) begin
                        next_r.rd_we = 1'b1;
                        next_r.rd_idx = hw2[11:8];
                        next_r.rd_data = spec_val;
                    end else if (is_msr) begin
                        if (sysm[7:3] == 5'h0 && !sysm[2]) begin
                            next_r.flags = REG_DATA_I[31:28];
                        end else if (sysm == BSX_SYS_MSP) begin
                            next_r.msp = {REG_DATA_I[31:2], 2'h0};
                        end else if (sysm == BSX_SYS_PSP) begin
                            next_r.psp = {REG_DATA_I[31:2], 2'h0};
                        end else if (sysm == BSX_SYS_INTERRUPT_MASK_BIT) begin
                            next_r.interrupt_mask_bit = REG_DATA_I[0];
                        end else if (sysm == BSX_SYS_CONTROL) begin
                            next_r.spsel = REG_DATA_I[1];
                        end
                    end else if (hw1 == BSX_ENC_SEV) begin
                        next_r.send_event = 1'b1;
                    end else if (hw1 == BSX_ENC_WFE) begin
                        if (!r.ctrl[BSX_CTRL_SLEEP_NOP] && !r.evt) begin
                            next_r.st = BSX_SLEEP_EVT;
                        end
                    end else if (hw1 == BSX_ENC_WFI) begin
                        if (!r.ctrl[BSX_CTRL_SLEEP_NOP]) begin
                            next_r.st = BSX_SLEEP_INT;
                        end
                    end
                    // no-operation and unknown words simply retire
                end
            end
            BSX_MEMWAIT: begin
                // hold later instructions until accesses complete
                if (MEM_IDLE_I) begin
                    next_r.st = BSX_IDLE;
                end
            end
            BSX_SLEEP_EVT: begin
                if (EXC_REQ_I || (PEND_NEW_I && r.ctrl[BSX_CTRL_WAKE_PEND])
                    || (DBG_REQ_I && DBG_EN_I) || EXT_EVENT_I) begin
                    next_r.st = BSX_IDLE;
                end
            end
            BSX_SLEEP_INT: begin
                if (EXC_REQ_I || PEND_PREEMPT_I || DBG_REQ_I) begin
                    next_r.st = BSX_IDLE;
                end
            end
            BSX_LOCK: begin
                next_r.st = BSX_LOCK;
            end
        endcase
        // event flop: set wins over the clear by a completing wait
        if (accept && hw1 == BSX_ENC_WFE && r.evt) begin
            next_r.evt = 1'b0;
        end
        if ((accept && hw1 == BSX_ENC_SEV) || (EXT_EVENT_I && r.st != BSX_SLEEP_EVT)) begin
            next_r.evt = 1'b1;
        end
        // APB: read data latched in setup, write taken in access phase
        if (PSEL && !PENABLE) begin
            next_r.pslverr = !apb_hit;
            next_r.prdata = 32'h0;
            if (apb_off == BSX_ADDR_CTRL) begin
                next_r.prdata = {29'h0, r.ctrl};
            end else if (apb_off == BSX_ADDR_STATUS) begin
                next_r.prdata[BSX_STAT_EVENT] = r.evt;
                next_r.prdata[BSX_STAT_INTERRUPT_MASK_BIT] = r.interrupt_mask_bit;
                next_r.prdata[BSX_STAT_TBIT] = r.tbit;
                next_r.prdata[BSX_STAT_SLEEP] = (r.st == BSX_SLEEP_EVT)
                                                 || (r.st == BSX_SLEEP_INT);
                next_r.prdata[BSX_STAT_LOCKUP] = (r.st == BSX_LOCK);
                next_r.prdata[BSX_STAT_FLAGS +: 4] = r.flags;
            end
        end
        if (PSEL && PENABLE && PWRITE && apb_off == BSX_ADDR_CTRL) begin
            next_r.ctrl = PWDATA[2:0];
        end
    end

    // State register, synchronous reset
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            r <= '0;
            r.st <= BSX_IDLE;
            r.tbit <= 1'b1;
            r.ctrl <= BSX_CTRL_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Output drive, all from flops except the handshake
    assign BRANCH_O = r.branch;
    assign TARGET_O = r.target;
    assign RD_WE_O = r.rd_we;
    assign RD_IDX_O = r.rd_idx;
    assign RD_DATA_O = r.rd_data;
    assign FATAL_FAULT_O = r.fault;
    assign SVC_O = r.supervisor_call;
    assign DEBUG_HALT_O = r.halt;
    assign LOCKUP_O = (r.st == BSX_LOCK);
    assign FLUSH_O = r.flush | r.branch;
    assign EVENT_OUT_O = r.send_event;
    assign SLEEP_O = (r.st == BSX_SLEEP_EVT) || (r.st == BSX_SLEEP_INT);
    assign FLAGS_O = r.flags;
    assign INTERRUPT_MASK_BIT_O = r.interrupt_mask_bit;
    assign TBIT_O = r.tbit;
    assign PRDATA = r.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = r.pslverr & PSEL & PENABLE;

    // Checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);

    sequence s_take(logic hit);
        accept && hit;
    endsequence

    link_addr_a: assert property (s_take(is_bl) |=> RD_WE_O && RD_IDX_O == BSX_LR_IDX
        && RD_DATA_O == ($past(PC_I) + BSX_PC_AHEAD | 32'h1)) else $error("bad link value");
    lr_bit0_a: assert property (s_take(is_bl || is_bxl) |=> !RD_WE_O || RD_DATA_O[0])
        else $error("link bit 0 clear");
    bx_fault_a: assert property (s_take(is_bxl && !REG_DATA_I[0])
        |=> FATAL_FAULT_O && !BRANCH_O) else $error("even indirect target not faulted");
    bx_tbit_a: assert property (s_take(is_bxl)
        |=> TBIT_O == $past(REG_DATA_I[0]) && !TARGET_O[0]) else $error("bad T bit or target");
    flags_keep_a: assert property (s_take((is_b || is_bcond || is_bl || is_bxl)
        && !FLAGS_WE_I) |=> $stable(FLAGS_O)) else $error("branch changed flags");
    mask_set_a: assert property (s_take(hw1 == BSX_ENC_MASK_SET)
        |=> INTERRUPT_MASK_BIT_O ##1 $stable(FLAGS_O) || $past(FLAGS_WE_I))
        else $error("mask not set");
    dsb_hold_a: assert property (r.st == BSX_MEMWAIT && !MEM_IDLE_I
        |-> !INSTR_READY_O ##1 !INSTR_READY_O || $past(MEM_IDLE_I))
        else $error("barrier released early");
    sev_set_a: assert property (s_take(hw1 == BSX_ENC_SEV)
        |=> EVENT_OUT_O && r.evt) else $error("send event lost");
    wfe_fast_a: assert property (s_take(hw1 == BSX_ENC_WFE && r.evt && !EXT_EVENT_I)
        |=> !r.evt && INSTR_READY_O) else $error("wait with event did not complete");
    wfi_wake_a: assert property (r.st == BSX_SLEEP_INT && DBG_REQ_I
        |=> INSTR_READY_O) else $error("debug request did not wake");
    svc_a: assert property (s_take(is_svc) |=> SVC_O [*1] ##1 !SVC_O)
        else $error("supervisor call not raised once");
endmodule : bsx_exec
`default_nettype wire

// ### testbench/bsx_regmodel.sv
/*
 * Register file partner for the execute unit: answers a read index.
 * Assumes the index is driven combinationally by the unit.
 */
`timescale 1ns/100ps
`default_nettype none
module bsx_regmodel (
    input wire logic [3:0] idx_i,
    output logic [31:0] data_o
);
    // Odd indices give odd values, so both indirect branch outcomes occur
    assign data_o = {4'h2, 20'h00000, idx_i, 3'h0, idx_i[0]};
endmodule : bsx_regmodel
`default_nettype wire

// ### testbench/testbench.sv
/*
 * Self-checking bench: issues instructions and APB cycles, checks results.
 * Assumes the execute unit answers one cycle after taking an instruction.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench
    import bsx_pkg::*;
;
    logic clk = 0, rst = 1, iv = 0, fwe = 0, midle = 1, dbg = 1, ev = 0;
    logic psel = 0, pen = 0, pw = 0, er, dreq = 0;
    wire logic lck;
    logic [3:0] fl = 4'h0;
    logic [7:0] pa = 8'h00;
    logic [31:0] ins = 32'h0, pc = 32'h0, pwd = 32'h0, rd;
    wire logic rdy, br, rwe, ff, supervisor_call, hlt, fls, evo, slp, msk, tb, prdy, perr;
    wire logic [3:0] ridx, rdi, flo;
    wire logic [31:0] rdat, tgt, rdd, prd;
    int n_fail = 0, compares = 0, cyc = 0;

    always #50 clk = ~clk;

    bsx_regmodel bsx_regmodel_i (.idx_i(rdi), .data_o(rdat));
    // Exception sources are tied quiet: wake paths are taken by an event (wait for event) and a debug request (wait for interrupt) here
    bsx_exec bsx_exec_i (.REF_CLK_I(clk), .SRST_I(rst), .INSTR_VALID_I(iv),
        .INSTR_I(ins), .PC_I(pc), .INSTR_READY_O(rdy), .REG_IDX_O(rdi),
        .REG_DATA_I(rdat), .FLAGS_WE_I(fwe), .FLAGS_I(fl), .EXC_NUM_I(6'h00),
        .MEM_IDLE_I(midle), .DEBUGGER_I(dbg), .DBG_EN_I(dbg), .DBG_REQ_I(dreq),
        .EXC_REQ_I(1'b0), .PEND_NEW_I(1'b0), .PEND_PREEMPT_I(1'b0),
        .EXT_EVENT_I(ev), .BRANCH_O(br), .TARGET_O(tgt), .RD_WE_O(rwe),
        .RD_IDX_O(ridx), .RD_DATA_O(rdd), .FATAL_FAULT_O(ff), .SVC_O(supervisor_call),
        .DEBUG_HALT_O(hlt), .LOCKUP_O(lck), .FLUSH_O(fls), .EVENT_OUT_O(evo),
        .SLEEP_O(slp), .FLAGS_O(flo), .INTERRUPT_MASK_BIT_O(msk), .TBIT_O(tb),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pw), .PADDR(pa), .PWDATA(pwd),
        .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // A hung handshake ends the run as a failure
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Holds valid until ready is seen; returns in the result cycle
    task automatic issue(input logic [31:0] w, input logic [31:0] a);
        int n;
        n = 0;
        @(posedge clk);
        iv <= 1'b1;
        ins <= w;
        pc <= a;
        @(negedge clk);
        while (rdy !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        iv <= 1'b0;
        @(negedge clk);
    endtask : issue

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pw <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        issue(32'hf802f000, 32'h100);
        chk("branch", 1, br);
        chk("target", 32'h108, tgt);
        chk("link idx", BSX_LR_IDX, ridx);
        chk("link data", 32'h105, rdd);
        issue(32'h4788, 32'h200);
        chk("target", 32'h20000010, tgt);
        chk("link data", 32'h203, rdd);
        chk("tbit", 1, tb);
        issue(32'h4710, 32'h300);
        chk("fault", 1, ff);
        chk("branch", 0, br);
        chk("tbit", 0, tb);
        $display("test branches done");
        @(posedge clk);
        fwe <= 1'b1;
        fl <= 4'h4;
        @(posedge clk);
        fwe <= 1'b0;
        issue(32'hd080, 32'h400);
        chk("target", 32'h304, tgt);
        chk("flags", 32'h4, flo);
        issue(32'hd180, 32'h500);
        chk("branch", 0, br);
        issue(32'hb672, 32'h502);
        chk("mask", 1, msk);
        issue(32'h8310f3ef, 32'h504);
        chk("mrs idx", 3, ridx);
        chk("mrs data", 1, rdd);
        issue(32'hb662, 32'h508);
        chk("mask", 0, msk);
        chk("flags", 32'h4, flo);
        $display("test conditions and mask done");
        issue(32'hbf40, 32'h50a);
        chk("event out", 1, evo);
        apb(1'b0, BSX_ADDR_STATUS, 32'h0);
        chk("event bit", 1, rd[BSX_STAT_EVENT]);
        issue(32'hbf20, 32'h50c);
        chk("ready", 1, rdy);
        issue(32'hbf20, 32'h50e);
        chk("sleep", 1, slp);
        @(posedge clk);
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
        @(negedge clk);
        chk("wake", 1, rdy);
        $display("test events done");
        @(posedge clk);
        midle <= 1'b0;
        issue(32'h8f4ff3bf, 32'h510);
        repeat (2) @(negedge clk);
        chk("barrier hold", 0, rdy);
        @(posedge clk);
        midle <= 1'b1;
        repeat (2) @(negedge clk);
        chk("barrier done", 1, rdy);
        issue(32'h8f6ff3bf, 32'h514);
        chk("flush", 1, fls);
        issue(32'hdf32, 32'h518);
        chk("svc", 1, supervisor_call);
        issue(32'hbe07, 32'h51a);
        chk("halt", 1, hlt);
        $display("test system done");
        apb(1'b0, 8'h08, 32'h0);
        chk("slverr", 1, er);
        apb(1'b1, BSX_ADDR_CTRL, 32'h1);
        apb(1'b0, BSX_ADDR_CTRL, 32'h0);
        chk("ctrl", 32'h1, rd);
        issue(32'hbf30, 32'h51c);
        chk("wfi nop", 0, slp);
        @(posedge clk);
        dbg <= 1'b0;
        apb(1'b1, BSX_ADDR_CTRL, 32'h0);
        issue(32'hbe00, 32'h51e);
        chk("debug_halt_instr fault", 1, ff);
        issue(32'hbf30, 32'h520);
        chk("wfi sleep", 1, slp);
        @(posedge clk);
        dreq <= 1'b1;
        @(posedge clk);
        dreq <= 1'b0;
        @(negedge clk);
        chk("wfi wake", 1, rdy);
        apb(1'b1, BSX_ADDR_CTRL, 32'h2);
        issue(32'hbe00, 32'h522);
        chk("lockup", 1, lck);
        chk("lock ready", 0, rdy);
        // Second reset mid-run is the only way out of lockup
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("lockup cleared", 0, lck);
        chk("reset ready", 1, rdy);
        chk("reset tbit", 1, tb);
        $display("test registers done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
